/* modbus_pdu_pkg.sv */
// Overview of operation
// R1 - Ignore server addresses 248-253 and 255
// R2 - Always answer catch-all test address 254
// R3 - No broadcast handling for address zero
// R4 - Finish any reply within 180 ms
// R5 - Client abandons wait after 180 ms
// R6 - Malformed request gets no reply
// R7 - Unimplemented code: code+0x80, exception 0x01
// R8 - Reserved register or excess count: exception 0x02
// R9 - Coil, discrete, single-write codes are unimplemented
// R10 - Holding read: 0x03, address, quantity, high first
// R11 - Read reply: code, 2N count, N words
// R12 - Holding read bad address: 0x83, 0x02
// R13 - Holding read bad quantity: 0x83, 0x03
// R14 - Input read 0x04, same layout, max 32
// R15 - Input read errors: 0x84 with 0x02/0x03
// R16 - Multi-write targets holding 0x0000-0x002F only
// R17 - Client write: 0x10, address, count, 2N, data
// R18 - Write reply echoes code, address, count
// R19 - Link is 9600 8N1 byte characters; code passes bytes on a parallel valid/ready link, BAUD_RATE unused
// R20 - Address equals register number minus one
// R21 - Register words sent high byte first
// R22 - Other server addresses discarded silently
//
// Shared constants and types for both ends of the request link.
// Assumes both ends run on one 25 MHz clock.
package modbus_pdu_pkg;

	// Server address classes
	localparam logic [7:0] ADDR_BCAST   = 8'h00;
	localparam logic [7:0] ADDR_IND_MAX = 8'hF7;
	localparam logic [7:0] ADDR_ANY     = 8'hFE;

	// Function and exception codes
	localparam logic [7:0] FC_RD_HR      = 8'h03;
	localparam logic [7:0] FC_RD_IR      = 8'h04;
	localparam logic [7:0] FC_WR_MULTI   = 8'h10;
	localparam logic [7:0] FC_EXC_FLAG   = 8'h80;
	localparam logic [7:0] EXC_ILL_FUNC  = 8'h01;
	localparam logic [7:0] EXC_ILL_ADDR  = 8'h02;
	localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

	// Register spaces
	localparam logic [15:0] HR_LAST_ADDR = 16'h002F;
	localparam int          HR_NUM       = 48;
	localparam int          IR_NUM       = 32;
	localparam logic [15:0] IR_MAX_QTY   = 16'h0020;

	// Frame lengths in bytes, address byte included
	localparam logic [7:0] RD_REQ_LEN    = 8'h06;
	localparam logic [7:0] WR_HDR_LEN    = 8'h07;
	localparam logic [7:0] MIN_FRAME_LEN = 8'h02;
	localparam logic [7:0] MAX_FRAME_LEN = 8'h67;
	localparam logic [7:0] RD_RSP_HDR    = 8'h03;
	localparam logic [7:0] EXC_RSP_LEN   = 8'h03;
	localparam logic [7:0] ECHO_RSP_LEN  = 8'h06;

	// Timing
	localparam int BAUD_RATE       = 9600;
	localparam int RESP_TIMEOUT_MS = 180;
	localparam int CLK_PERIOD_NS   = 40;
	localparam int RESP_CYCLES     =
		RESP_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int TMR_W           = 23;

	typedef enum logic [1:0] {
		ST_RX     = 2'b00,
		ST_CHECK  = 2'b01,
		ST_COMMIT = 2'b11,
		ST_TX     = 2'b10
	} dev_state_t;

	typedef enum logic [1:0] {
		K_READ_HR = 2'b00,
		K_READ_IR = 2'b01,
		K_ECHO    = 2'b11,
		K_EXC     = 2'b10
	} rsp_kind_t;

	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_SEND = 2'b01,
		H_WAIT = 2'b11
	} host_state_t;

endpackage

/* modbus_pdu_if.sv */
// Byte-stream link carrying request and reply frames.
// Assumes both ends share core_clk; the testbench joins them.
`timescale 1ns/1ps
interface modbus_pdu_if;
	// Eight-bit characters as on the 8N1 serial line [R19]
	logic       req_valid;
	logic [7:0] req_data;
	logic       req_last;
	logic       req_ready;
	logic       rsp_valid;
	logic [7:0] rsp_data;
	logic       rsp_last;
	logic       rsp_ready;

	modport dev (
		input  req_valid,
		input  req_data,
		input  req_last,
		output req_ready,
		output rsp_valid,
		output rsp_data,
		output rsp_last,
		input  rsp_ready
	);

	modport host (
		output req_valid,
		output req_data,
		output req_last,
		input  req_ready,
		input  rsp_valid,
		input  rsp_data,
		input  rsp_last,
		output rsp_ready
	);
endinterface

/* modbus_pdu_server.sv */
// Server end: filters, checks and answers request frames.
// Assumes own_addr and ir_values come from logic on core_clk.
`timescale 1ns/1ps
module modbus_pdu_server
	import modbus_pdu_pkg::*;
#(
	parameter int RESP_LIMIT = RESP_CYCLES
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	modbus_pdu_if.dev                  link,
	input  wire logic [7:0]            own_addr,
	input  wire logic [IR_NUM*16-1:0]  ir_values,
	output logic      [HR_NUM*16-1:0]  hr_values,
	output logic                       wr_done,
	output logic                       deadline_miss
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	dev_state_t       state_r;
	rsp_kind_t        kind_r;
	logic [7:0]       hdr   [0:6];
	logic [15:0]      wbuf  [0:HR_NUM-1];
	logic [7:0]       rx_cnt_r;
	logic [7:0]       tx_idx_r;
	logic [7:0]       tx_len_r;
	logic [7:0]       exc_code_r;
	logic [5:0]       cm_idx_r;
	logic [TMR_W-1:0] dl_cnt_r;
	logic             req_ready_r, rsp_valid_r, rsp_last_r;
	logic [7:0]       rsp_data_r;

	assign link.req_ready = req_ready_r;
	assign link.rsp_valid = rsp_valid_r;
	assign link.rsp_data  = rsp_data_r;
	assign link.rsp_last  = rsp_last_r;

	// ---------------------------------------------------------------
	// Decode of the captured frame
	// ---------------------------------------------------------------
	logic        rx_take, tx_take, tx_end, dl_hit, addressed;
	logic [15:0] start_w;
	logic [15:0] qty_w;
	logic [16:0] end_w;
	logic [7:0]  b_idx;

	assign rx_take = (state_r == ST_RX) && link.req_valid && req_ready_r;
	assign tx_take = (state_r == ST_TX) && rsp_valid_r && link.rsp_ready;
	assign tx_end  = tx_take && (tx_idx_r == tx_len_r - 8'h01);
	assign dl_hit  = dl_cnt_r == TMR_W'(RESP_LIMIT - 1);
	assign start_w = {hdr[2], hdr[3]};
	assign qty_w   = {hdr[4], hdr[5]};
	assign end_w   = {1'b0, start_w} + {1'b0, qty_w};
	assign b_idx   = rx_cnt_r - WR_HDR_LEN;

	// Own individual address or catch-all; 0, reserved, others drop
	assign addressed = (hdr[0] == ADDR_ANY) ||                 // [R2]
		((hdr[0] == own_addr) && (own_addr != ADDR_BCAST) &&   // [R3]
		 (own_addr <= ADDR_IND_MAX));                 // [R1] [R22]

	// Reply byte at a given position of the answer frame
	function automatic logic [7:0] rsp_byte(input logic [7:0] idx);
		logic [7:0]  k;
		logic [5:0]  ri;
		logic [15:0] w;
		k  = idx - RD_RSP_HDR;
		ri = hdr[3][5:0] + k[6:1];             // Zero-based address [R20]
		if (kind_r == K_READ_IR)
			w = ir_values[ri[4:0]*16 +: 16];
		else
			w = hr_values[ri*16 +: 16];
		if (idx == 8'h00)
			rsp_byte = hdr[0];
		else if (idx == 8'h01)
			rsp_byte = (kind_r == K_EXC) ? (hdr[1] | FC_EXC_FLAG)
				: hdr[1];                      // [R7] [R11] [R18]
		else if (kind_r == K_EXC)
			rsp_byte = exc_code_r;
		else if (kind_r == K_ECHO)
			rsp_byte = hdr[idx[2:0]];                 // [R18]
		else if (idx == 8'h02)
			rsp_byte = {hdr[5][6:0], 1'b0};           // [R11]
		else
			rsp_byte = k[0] ? w[7:0] : w[15:8];       // [R21]
	endfunction

	// ---------------------------------------------------------------
	// Request capture
	// ---------------------------------------------------------------
	// Header bytes and staged write data
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 7; i++)
				hdr[i] <= 8'h00;
			for (int i = 0; i < HR_NUM; i++)
				wbuf[i] <= 16'h0000;
		end else if (rx_take) begin
			if (rx_cnt_r < WR_HDR_LEN)
				hdr[rx_cnt_r[2:0]] <= link.req_data;  // [R10] [R14]
			else if (rx_cnt_r < MAX_FRAME_LEN) begin
				if (b_idx[0])
					wbuf[b_idx[6:1]][7:0]  <= link.req_data;
				else
					wbuf[b_idx[6:1]][15:8] <= link.req_data; // [R21]
			end
		end
	end

	// Byte count of the frame, saturating
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			rx_cnt_r <= 8'h00;
		else if (state_r == ST_CHECK)
			rx_cnt_r <= 8'h00;
		else if (rx_take && rx_cnt_r != 8'hFF)
			rx_cnt_r <= rx_cnt_r + 8'h01;
	end

	// ---------------------------------------------------------------
	// Control and checking
	// ---------------------------------------------------------------
	// Main sequencer
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= ST_RX;
			kind_r      <= K_EXC;
			exc_code_r  <= 8'h00;
			tx_len_r    <= 8'h00;
			req_ready_r <= 1'b0;
		end else begin
			case (state_r)
			ST_RX: begin
				req_ready_r <= 1'b1;
				if (rx_take && link.req_last) begin
					req_ready_r <= 1'b0;
					state_r     <= ST_CHECK;
				end
			end
			ST_CHECK: begin
				state_r  <= ST_TX;
				kind_r   <= K_EXC;
				tx_len_r <= EXC_RSP_LEN;
				if (!addressed || rx_cnt_r < MIN_FRAME_LEN ||
					rx_cnt_r > MAX_FRAME_LEN)
					state_r <= ST_RX;            // [R1] [R3] [R6] [R22]
				else if (hdr[1] == FC_RD_HR) begin
					if (rx_cnt_r != RD_REQ_LEN)
						state_r <= ST_RX;                     // [R6]
					else if (qty_w == 16'h0000 ||
						qty_w > 16'(HR_NUM))
						exc_code_r <= EXC_ILL_VALUE;          // [R13]
					else if (end_w > 17'(HR_NUM))
						exc_code_r <= EXC_ILL_ADDR;      // [R8] [R12]
					else begin
						kind_r   <= K_READ_HR;
						tx_len_r <= RD_RSP_HDR + {qty_w[6:0], 1'b0};
					end
				end else if (hdr[1] == FC_RD_IR) begin
					if (rx_cnt_r != RD_REQ_LEN)
						state_r <= ST_RX;                     // [R6]
					else if (qty_w == 16'h0000 || qty_w > IR_MAX_QTY)
						exc_code_r <= EXC_ILL_VALUE;     // [R14] [R15]
					else if (end_w > 17'(IR_NUM))
						exc_code_r <= EXC_ILL_ADDR;      // [R8] [R15]
					else begin
						kind_r   <= K_READ_IR;
						tx_len_r <= RD_RSP_HDR + {qty_w[6:0], 1'b0};
					end
				end else if (hdr[1] == FC_WR_MULTI) begin
					if (rx_cnt_r < WR_HDR_LEN || qty_w > 16'h0080 ||
						hdr[6] != {qty_w[6:0], 1'b0} ||
						rx_cnt_r != WR_HDR_LEN + hdr[6])
						state_r <= ST_RX;               // [R6] [R17]
					else if (qty_w == 16'h0000)
						exc_code_r <= EXC_ILL_VALUE;
					else if (end_w > {1'b0, HR_LAST_ADDR} + 17'h0_0001)
						exc_code_r <= EXC_ILL_ADDR;      // [R8] [R16]
					else begin
						kind_r   <= K_ECHO;
						tx_len_r <= ECHO_RSP_LEN;
						state_r  <= ST_COMMIT;
					end
				end else
					exc_code_r <= EXC_ILL_FUNC;          // [R7] [R9]
			end
			ST_COMMIT: begin
				if (dl_hit)
					state_r <= ST_RX;                         // [R4]
				else if (cm_idx_r == qty_w[5:0] - 6'h01)
					state_r <= ST_TX;
			end
			ST_TX: begin
				if (tx_end || dl_hit)
					state_r <= ST_RX;                         // [R4]
			end
			default: state_r <= ST_RX;
			endcase
		end
	end

	// Holding registers, written only after a clean check
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hr_values <= '0;
			cm_idx_r  <= 6'h00;
		end else if (state_r == ST_COMMIT) begin
			hr_values[(hdr[3][5:0] + cm_idx_r)*16 +: 16] <=
				wbuf[cm_idx_r];                            // [R16]
			cm_idx_r <= cm_idx_r + 6'h01;
		end else
			cm_idx_r <= 6'h00;
	end

	// Pulse when a write has been stored
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			wr_done <= 1'b0;
		else
			wr_done <= (state_r == ST_COMMIT) && !dl_hit &&
				(cm_idx_r == qty_w[5:0] - 6'h01);
	end

	// ---------------------------------------------------------------
	// Reply transmit and deadline
	// ---------------------------------------------------------------
	// Reply byte stream
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_idx_r    <= 8'h00;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 8'h00;
			rsp_last_r  <= 1'b0;
		end else if (state_r != ST_TX) begin
			tx_idx_r    <= 8'h00;
			rsp_valid_r <= 1'b0;
			rsp_last_r  <= 1'b0;
		end else if (dl_hit || tx_end) begin
			rsp_valid_r <= 1'b0;                              // [R4]
			rsp_last_r  <= 1'b0;
		end else if (!rsp_valid_r) begin
			rsp_valid_r <= 1'b1;
			rsp_data_r  <= rsp_byte(8'h00);
		end else if (tx_take) begin
			tx_idx_r   <= tx_idx_r + 8'h01;
			rsp_data_r <= rsp_byte(tx_idx_r + 8'h01);
			rsp_last_r <= (tx_idx_r + 8'h02 == tx_len_r);
		end
	end

	// Response time budget from end of request
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dl_cnt_r      <= '0;
			deadline_miss <= 1'b0;
		end else begin
			deadline_miss <= dl_hit && (state_r != ST_RX);    // [R4]
			if (state_r == ST_RX || dl_hit)
				dl_cnt_r <= '0;
			else
				dl_cnt_r <= dl_cnt_r + TMR_W'(1);
		end
	end

endmodule

/* modbus_pdu_client.sv */
// Client end: forms request frames and collects replies.
// Assumes the command port is driven from logic on core_clk.
`timescale 1ns/1ps
module modbus_pdu_client
	import modbus_pdu_pkg::*;
#(
	parameter int RESP_LIMIT = RESP_CYCLES
) (
	input  wire logic                  core_clk,
	input  wire logic                  rst_n,
	modbus_pdu_if.host                 link,
	input  wire logic                  cmd_valid,
	input  wire logic [7:0]            cmd_server,
	input  wire logic [7:0]            cmd_fc,
	input  wire logic [15:0]           cmd_start,
	input  wire logic [15:0]           cmd_qty,
	input  wire logic [HR_NUM*16-1:0]  cmd_wdata,
	output logic                       cmd_ready,
	output logic                       out_valid,
	output logic [7:0]                 out_data,
	output logic                       out_last,
	output logic                       rsp_exc,
	output logic                       done,
	output logic                       timeout
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	host_state_t        state_r;
	logic [7:0]         server_r;
	logic [7:0]         fc_r;
	logic [15:0]        start_r;
	logic [15:0]        qty_r;
	logic [HR_NUM*16-1:0] wdata_r;
	logic [7:0]         idx_r;
	logic [7:0]         len_r;
	logic [7:0]         rx_idx_r;
	logic [TMR_W-1:0]   to_cnt_r;
	logic               req_valid_r, req_last_r, rsp_ready_r;
	logic [7:0]         req_data_r;
	logic               send_take, rx_take;

	assign link.req_valid = req_valid_r;
	assign link.req_data  = req_data_r;
	assign link.req_last  = req_last_r;
	assign link.rsp_ready = rsp_ready_r;
	assign send_take = req_valid_r && link.req_ready;
	assign rx_take   = (state_r == H_WAIT) && rsp_ready_r &&
		link.rsp_valid;

	// Request byte at a given position
	function automatic logic [7:0] req_byte(input logic [7:0] idx);
		logic [7:0]  k;
		logic [15:0] w;
		k = idx - WR_HDR_LEN;
		w = wdata_r[k[6:1]*16 +: 16];
		case (idx)
		8'h00:   req_byte = server_r;
		8'h01:   req_byte = fc_r;
		8'h02:   req_byte = start_r[15:8];           // [R10] [R14]
		8'h03:   req_byte = start_r[7:0];
		8'h04:   req_byte = qty_r[15:8];
		8'h05:   req_byte = qty_r[7:0];
		8'h06:   req_byte = {qty_r[6:0], 1'b0};            // [R17]
		default: req_byte = k[0] ? w[7:0] : w[15:8];       // [R21]
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	// Command latch, send and wait
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r     <= H_IDLE;
			server_r    <= 8'h00;
			fc_r        <= 8'h00;
			start_r     <= 16'h0000;
			qty_r       <= 16'h0000;
			wdata_r     <= '0;
			len_r       <= 8'h00;
			idx_r       <= 8'h00;
			cmd_ready   <= 1'b0;
			req_valid_r <= 1'b0;
			req_data_r  <= 8'h00;
			req_last_r  <= 1'b0;
		end else begin
			case (state_r)
			H_IDLE: begin
				cmd_ready <= 1'b1;
				if (cmd_valid && cmd_ready) begin
					cmd_ready <= 1'b0;
					server_r  <= cmd_server;
					fc_r      <= cmd_fc;
					start_r   <= cmd_start;
					qty_r     <= cmd_qty;
					wdata_r   <= cmd_wdata;
					idx_r     <= 8'h00;
					if (cmd_fc == FC_RD_HR || cmd_fc == FC_RD_IR)
						len_r <= RD_REQ_LEN;
					else if (cmd_fc == FC_WR_MULTI)
						len_r <= WR_HDR_LEN + {cmd_qty[6:0], 1'b0};
					else
						len_r <= MIN_FRAME_LEN;
					state_r <= H_SEND;
				end
			end
			H_SEND: begin
				if (!req_valid_r) begin
					req_valid_r <= 1'b1;
					req_data_r  <= req_byte(8'h00);
					req_last_r  <= (len_r == 8'h01);
				end else if (send_take) begin
					if (req_last_r) begin
						req_valid_r <= 1'b0;
						req_last_r  <= 1'b0;
						state_r     <= H_WAIT;
					end else begin
						idx_r      <= idx_r + 8'h01;
						req_data_r <= req_byte(idx_r + 8'h01);
						req_last_r <= (idx_r + 8'h02 == len_r);
					end
				end
			end
			H_WAIT: begin
				if ((rx_take && link.rsp_last) ||
					to_cnt_r == TMR_W'(RESP_LIMIT - 1))
					state_r <= H_IDLE;                        // [R5]
			end
			default: state_r <= H_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Reply collection and time-out
	// ---------------------------------------------------------------
	// Pass reply bytes to the user side
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_ready_r <= 1'b0;
			rx_idx_r    <= 8'h00;
			out_valid   <= 1'b0;
			out_data    <= 8'h00;
			out_last    <= 1'b0;
			rsp_exc     <= 1'b0;
			done        <= 1'b0;
		end else begin
			rsp_ready_r <= (state_r == H_WAIT) &&
				!(rx_take && link.rsp_last);
			out_valid   <= rx_take;
			out_last    <= rx_take && link.rsp_last;
			done        <= rx_take && link.rsp_last;
			if (state_r != H_WAIT)
				rx_idx_r <= 8'h00;
			else if (rx_take) begin
				out_data <= link.rsp_data;
				rx_idx_r <= rx_idx_r + 8'h01;
				if (rx_idx_r == 8'h01)
					rsp_exc <= link.rsp_data[7];              // [R7]
			end
		end
	end

	// Abandon the wait after the response time-out
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			to_cnt_r <= '0;
			timeout  <= 1'b0;
		end else begin
			timeout <= (state_r == H_WAIT) && !(rx_take && link.rsp_last)
				&& (to_cnt_r == TMR_W'(RESP_LIMIT - 1));     // [R5]
			if (state_r != H_WAIT)
				to_cnt_r <= '0;
			else
				to_cnt_r <= to_cnt_r + TMR_W'(1);
		end
	end

endmodule

/* modbus_pdu_monitor.sv */
// Checker for the byte link between the two ends.
// Assumes every signal sits on core_clk with rst_n as async reset.
`timescale 1ns/1ps
module modbus_pdu_monitor
	import modbus_pdu_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       req_valid,
	input wire logic [7:0] req_data,
	input wire logic       req_last,
	input wire logic       req_ready,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last,
	input wire logic       rsp_ready
);
	localparam int REPLY_BOUND = 240;
	logic [7:0]  req_idx_r, rsp_idx_r, fc;
	logic [47:0] req_b_r;
	logic        exc_r, rd;
	logic [15:0] qty;

	// Decoded header of the frame last sent
	assign fc  = req_b_r[15:8];
	assign qty = {req_b_r[39:32], req_b_r[47:40]};
	assign rd  = (fc == FC_RD_HR) || (fc == FC_RD_IR);

	// Request byte position and first six bytes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_idx_r <= 8'h00;
			req_b_r   <= '0;
		end else if (req_valid && req_ready) begin
			req_idx_r <= req_last ? 8'h00 : req_idx_r + 8'h01;
			if (req_idx_r < 8'h06)
				req_b_r[8*req_idx_r[2:0] +: 8] <= req_data;
		end
	end

	// Reply byte position and exception flag
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_idx_r <= 8'h00;
			exc_r     <= 1'b0;
		end else if (rsp_valid && rsp_ready) begin
			rsp_idx_r <= rsp_last ? 8'h00 : rsp_idx_r + 8'h01;
			if (rsp_idx_r == 8'h01)
				exc_r <= rsp_data[7];
		end
	end

	// ----------------------------------------
	// Link assertions
	// ----------------------------------------
	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	req_hold_a: assert property (
		req_valid && !req_ready |=> req_valid && $stable(req_data)
		&& $stable(req_last)) else $error("request byte not held");
	rsp_hold_a: assert property (
		rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data)
		&& $stable(rsp_last)) else $error("reply byte not held");
	req_drop_a: assert property (
		req_valid && req_ready && req_last |=> !req_ready)
		else $error("ready stayed after last byte");
	reply_time_a: assert property (
		req_valid && req_ready && req_last |=> ##[0:REPLY_BOUND] req_ready)
		else $error("reply not finished in time");
	resv_addr_a: assert property (
		rsp_valid |-> !(req_b_r[7:0] >= 8'hF8 && req_b_r[7:0] != ADDR_ANY))
		else $error("reply to reserved address");
	no_bcast_a: assert property (
		rsp_valid |-> req_b_r[7:0] != ADDR_BCAST)
		else $error("reply to broadcast");
	addr_echo_a: assert property (
		rsp_valid && rsp_idx_r == 8'h00 |-> rsp_data == req_b_r[7:0])
		else $error("reply address differs");
	fc_echo_a: assert property (
		rsp_valid && rsp_idx_r == 8'h01 |-> rsp_data[6:0] == fc[6:0])
		else $error("reply function differs");
	exc_len_a: assert property (
		rsp_valid && rsp_idx_r == 8'h02 && exc_r |-> rsp_last)
		else $error("exception frame too long");
	unimpl_code_a: assert property (
		rsp_valid && rsp_idx_r == 8'h02 && exc_r && !rd && fc != FC_WR_MULTI
		|-> rsp_data == EXC_ILL_FUNC) else $error("wrong exception code");
	rd_count_a: assert property (
		rsp_valid && rsp_idx_r == 8'h02 && !exc_r && rd
		|-> rsp_data == {qty[6:0], 1'b0}) else $error("wrong byte count");
	rd_len_a: assert property (
		rsp_valid && rsp_last && rsp_idx_r > 8'h01 && !exc_r && rd
		|-> rsp_idx_r == {qty[6:0], 1'b0} + 8'h02)
		else $error("wrong read reply length");
	wr_echo_a: assert property (
		rsp_valid && rsp_idx_r > 8'h01 && !exc_r && fc == FC_WR_MULTI
		|-> rsp_data == req_b_r[8*rsp_idx_r[2:0] +: 8]
		&& rsp_last == (rsp_idx_r == 8'h05)) else $error("bad write echo");
endmodule

/* tb_top.sv */
// Testbench for both ends over the byte link.
// Assumes the package and interface compile first.
`timescale 1ns/1ps
module tb_top
	import modbus_pdu_pkg::*;
;
	localparam int LIM = 200;
	localparam logic [47:0] EXC_TAB [0:15] = '{
		48'h0300_0000_0003, 48'h0300_0000_3103, 48'h0300_3000_0102,
		48'h0300_2F00_0202, 48'h0400_0000_0003, 48'h0400_0000_2103,
		48'h0400_1F00_0202, 48'h1000_0000_0003, 48'h1000_2F00_0202,
		48'h0100_0000_0001, 48'h0200_0000_0001, 48'h0500_0000_0001,
		48'h0600_0000_0001, 48'h0F00_0000_0001, 48'h2B00_0000_0001,
		48'h1700_0000_0001};
	localparam logic [7:0] DROP_TAB [0:4] = '{8'h00, 8'hF8, 8'hFD,
		8'hFF, 8'h22};
	logic                 core_clk, rst_n, cmd_valid, cmd_ready;
	logic                 out_valid, out_last, rsp_exc, done, timeout;
	logic                 done_seen, to_seen;
	logic [7:0]           own_addr, cmd_server, cmd_fc, out_data;
	logic [15:0]          cmd_start, cmd_qty;
	logic [IR_NUM*16-1:0] ir_values;
	logic [HR_NUM*16-1:0] hr_values, hr_values_b, cmd_wdata;
	logic [7:0]           rx_q[$], exp_q[$];
	int                   wait_cyc, n_fail, check_count;

	modbus_pdu_if lnk();
	modbus_pdu_if lnk_b();

	modbus_pdu_server #(.RESP_LIMIT(LIM)) i_modbus_pdu_server (
		.core_clk(core_clk), .rst_n(rst_n), .link(lnk),
		.own_addr(own_addr), .ir_values(ir_values),
		.hr_values(hr_values), .wr_done(), .deadline_miss());
	modbus_pdu_server #(.RESP_LIMIT(LIM)) i_modbus_pdu_server_b (
		.core_clk(core_clk), .rst_n(rst_n), .link(lnk_b),
		.own_addr(own_addr), .ir_values(ir_values),
		.hr_values(hr_values_b), .wr_done(), .deadline_miss());
	modbus_pdu_client #(.RESP_LIMIT(LIM)) i_modbus_pdu_client (
		.core_clk(core_clk), .rst_n(rst_n), .link(lnk),
		.cmd_valid(cmd_valid), .cmd_server(cmd_server), .cmd_fc(cmd_fc),
		.cmd_start(cmd_start), .cmd_qty(cmd_qty), .cmd_wdata(cmd_wdata),
		.cmd_ready(cmd_ready), .out_valid(out_valid), .out_data(out_data),
		.out_last(out_last), .rsp_exc(rsp_exc), .done(done),
		.timeout(timeout));
	modbus_pdu_monitor i_modbus_pdu_monitor (
		.core_clk(core_clk), .rst_n(rst_n),
		.req_valid(lnk.req_valid), .req_data(lnk.req_data),
		.req_last(lnk.req_last), .req_ready(lnk.req_ready),
		.rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data),
		.rsp_last(lnk.rsp_last), .rsp_ready(lnk.rsp_ready));

	// Clock at 25 MHz
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Collect reply bytes and completion pulses
	always @(negedge core_clk) begin
		if (out_valid === 1'b1)
			rx_q.push_back(out_data);
		if (done === 1'b1)
			done_seen = 1'b1;
		if (timeout === 1'b1)
			to_seen = 1'b1;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One command through the client, waiting for reply or time-out
	task automatic run(input logic [7:0] srv, input logic [7:0] fc,
		input logic [15:0] st, input logic [15:0] qty);
		rx_q.delete();
		done_seen = 1'b0;
		to_seen = 1'b0;
		wait_cyc = 0;
		while (cmd_ready !== 1'b1)
			@(negedge core_clk);
		cmd_valid = 1'b1;
		cmd_server = srv;
		cmd_fc = fc;
		cmd_start = st;
		cmd_qty = qty;
		@(negedge core_clk);
		cmd_valid = 1'b0;
		while (!done_seen && !to_seen && wait_cyc < 1000) begin
			@(negedge core_clk);
			wait_cyc++;
		end
		chk("reply wait", 1, wait_cyc < 1000);
		repeat (2) @(negedge core_clk);
	endtask

	task automatic cmp_reply(input string what);
		chk({what, " length"}, exp_q.size(), rx_q.size());
		foreach (exp_q[i])
			if (i < rx_q.size())
				chk(what, exp_q[i], rx_q[i]);
		chk({what, " done"}, 1, done_seen);
	endtask

	// Raw frame on the second link, then watch for silence
	task automatic send_raw(input logic [7:0] b[$]);
		int cnt;
		cnt = 0;
		foreach (b[i]) begin
			lnk_b.req_valid = 1'b1;
			lnk_b.req_data = b[i];
			lnk_b.req_last = (i == b.size() - 1);
			while (lnk_b.req_ready !== 1'b1)
				@(negedge core_clk);
			@(negedge core_clk);
		end
		lnk_b.req_valid = 1'b0;
		repeat (300) begin
			@(negedge core_clk);
			if (lnk_b.rsp_valid === 1'b1)
				cnt++;
		end
		chk("malformed silence", 0, cnt);
	endtask

	// Watchdog on a hung run
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		$display("FAIL watchdog expected finish seen hang");
		tally_and_finish();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		n_fail = 0;
		check_count = 0;
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd_wdata = '0;
		own_addr = 8'h21;
		for (int i = 0; i < IR_NUM; i++)
			ir_values[i*16 +: 16] = 16'hA500 + 16'(i);
		lnk_b.req_valid = 1'b0;
		lnk_b.req_data = 8'h00;
		lnk_b.req_last = 1'b0;
		lnk_b.rsp_ready = 1'b1;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		chk("idle ready", 1, cmd_ready);
		chk("holding reset", 0, hr_values[31:0]);
		$display("test reset ended");
		cmd_wdata[31:0] = 32'hBEEF_1234;
		run(8'h21, FC_WR_MULTI, 16'h002E, 16'h0002);
		exp_q = '{8'h21, 8'h10, 8'h00, 8'h2E, 8'h00, 8'h02};
		cmp_reply("write echo");
		chk("holding 46", 16'h1234, hr_values[46*16 +: 16]);
		chk("holding 47", 16'hBEEF, hr_values[47*16 +: 16]);
		run(8'h21, FC_RD_HR, 16'h002E, 16'h0002);
		exp_q = '{8'h21, 8'h03, 8'h04, 8'h12, 8'h34, 8'hBE, 8'hEF};
		cmp_reply("holding read");
		chk("holding read flag", 0, rsp_exc);
		run(8'h21, FC_RD_IR, 16'h0000, 16'h0020);
		exp_q = '{8'h21, 8'h04, 8'h40};
		for (int i = 0; i < IR_NUM; i++) begin
			exp_q.push_back(8'hA5);
			exp_q.push_back(8'(i));
		end
		cmp_reply("input read");
		run(ADDR_ANY, FC_RD_HR, 16'h002F, 16'h0001);
		exp_q = '{8'hFE, 8'h03, 8'h02, 8'hBE, 8'hEF};
		cmp_reply("catch-all read");
		$display("test normal replies ended");
		foreach (EXC_TAB[e]) begin
			run(8'h21, EXC_TAB[e][47:40], EXC_TAB[e][39:24],
				EXC_TAB[e][23:8]);
			exp_q = '{8'h21, EXC_TAB[e][47:40] | FC_EXC_FLAG,
				EXC_TAB[e][7:0]};
			cmp_reply("exception");
			chk("exception flag", 1, rsp_exc);
		end
		$display("test exceptions ended");
		cmd_wdata[15:0] = 16'hFFFF;
		foreach (DROP_TAB[d]) begin
			run(DROP_TAB[d], FC_WR_MULTI, 16'h0000, 16'h0001);
			chk("dropped bytes", 0, rx_q.size());
			chk("dropped time-out", 1, to_seen);
			chk("time-out span", 1, wait_cyc <= LIM + 60);
			chk("dropped no write", 0, hr_values[15:0]);
		end
		$display("test dropped frames ended");
		send_raw('{8'h21, 8'h03, 8'h00, 8'h00});
		send_raw('{8'h21, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h04,
			8'hAA, 8'hBB});
		chk("malformed no write", 0, hr_values_b[15:0]);
		$display("test malformed frames ended");
		tally_and_finish();
	end
endmodule
